// ### common/adcsel_defs.svh
`ifndef ADCSEL_DEFS_SVH
`define ADCSEL_DEFS_SVH

// conversion lengths in adc clock cycles
`define ADCSEL_NORMAL_LEN 5'd13
`define ADCSEL_FIRST_LEN 5'd25

// result code for an input above the selected reference
`define ADCSEL_FULL_SCALE 10'h3ff

// reference select codes
`define ADCSEL_REF_EXTERNAL 2'h0
`define ADCSEL_REF_SUPPLY 2'h1
`define ADCSEL_REF_INTERNAL 2'h3

// reference switch one-hot positions
`define ADCSEL_REFSW_EXTERNAL 0
`define ADCSEL_REFSW_SUPPLY 1
`define ADCSEL_REFSW_INTERNAL 2

// channel select codes
`define ADCSEL_CH_LAST_INPUT 4'h7
`define ADCSEL_CH_BANDGAP 4'he
`define ADCSEL_CH_GROUND 4'hf

// channel mux one-hot positions
`define ADCSEL_MUX_INPUTS 8
`define ADCSEL_MUX_BANDGAP 8
`define ADCSEL_MUX_GROUND 9

// reset values of the selection
`define ADCSEL_RESET_CHANNEL 4'h0
`define ADCSEL_RESET_REFERENCE 2'h0

`endif

// ### common/adcsel_pkg.sv
package adcsel_pkg;

  typedef enum logic [2:0] {
    SleepIdle,
    SleepNoiseReduce,
    SleepPowerDown,
    SleepPowerSave,
    SleepStandby
  } adcsel_sleep_type;

  typedef enum logic {
    PhaseIdle,
    PhaseConvert
  } adcsel_phase_type;

  typedef struct packed {
    adcsel_phase_type phase;
    logic [4:0] cycle;
    logic firstDone;
    logic startPending;
    logic [3:0] bufChannel;
    logic [1:0] bufReference;
    logic [3:0] appliedChannel;
    logic [1:0] appliedReference;
    logic [9:0] channelMux;
    logic [2:0] referenceSwitch;
    logic doneFlag;
    logic completeIrq;
    logic [9:0] result;
    logic [2:0] overSync;
    logic overRange;
    logic haltedPrev;
  } adcsel_state_type;

endpackage

// ### rtl/adcsel_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsel_defs.svh"

module adcsel_decode (
  input wire logic [3:0] channel,
  input wire logic [1:0] reference,
  output logic [9:0] channelMux,
  output logic [2:0] referenceSwitch
);

  // reserved codes select nothing
  genvar i;
  generate
    for (i = 0; i < `ADCSEL_MUX_INPUTS; i++) begin : gInput
      assign channelMux[i] = (channel == 4'(i)); // [R15]
    end
  endgenerate
  assign channelMux[`ADCSEL_MUX_BANDGAP] =
    (channel == `ADCSEL_CH_BANDGAP); // [R15]
  assign channelMux[`ADCSEL_MUX_GROUND] =
    (channel == `ADCSEL_CH_GROUND); // [R15]

  assign referenceSwitch[`ADCSEL_REFSW_EXTERNAL] =
    (reference == `ADCSEL_REF_EXTERNAL); // [R14]
  assign referenceSwitch[`ADCSEL_REFSW_SUPPLY] =
    (reference == `ADCSEL_REF_SUPPLY); // [R14]
  assign referenceSwitch[`ADCSEL_REFSW_INTERNAL] =
    (reference == `ADCSEL_REF_INTERNAL); // [R14]

endmodule

`default_nettype wire

// ### rtl/adcsel_top.sv
// Contract
// [R01] buffer copied to applied while no conversion
// [R02] applied selection frozen once conversion starts
// [R03] copying resumes in final adc clock cycle
// [R04] start bit begins conversion at next tick
// [R05] software waits one adc clock before reselecting
// [R06] auto trigger: reselect only at safe points
// [R07] free running: change hits the result after next
// [R08] input above reference gives full scale code
// [R09] software discards first result after reference change
// [R10] software prepares converter before noise canceler use
// [R11] idle or noise sleep starts conversion on halt
// [R12] completion raises interrupt request even after wake
// [R13] other sleep modes leave converter enabled
// [R14] reference field decode, code 10 reserved
// [R15] channel field decode, reserved codes select none
// [R16] mux and switch driven from applied copy only
`timescale 1ns/1ps
`default_nettype none
`include "adcsel_defs.svh"

module adcsel_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic adcClkTick,
  input wire logic selWrite,
  input wire logic [3:0] selWriteChannel,
  input wire logic [1:0] selWriteReference,
  input wire logic converterEnable,
  input wire logic autoTriggerEnable,
  input wire logic freeRunning,
  input wire logic conversionStartWrite,
  input wire logic triggerEvent,
  input wire logic doneFlagClear,
  input wire logic completeIrqEnable,
  input wire adcsel_pkg::adcsel_sleep_type sleepMode,
  input wire logic cpuHalted,
  input wire logic [9:0] sarCode,
  input wire logic overRangePin,
  output logic conversionBusy,
  output logic conversionDoneFlag,
  output logic completeIrq,
  output logic [3:0] bufferChannel,
  output logic [1:0] bufferReference,
  output logic [3:0] appliedChannel,
  output logic [1:0] appliedReference,
  output logic [9:0] channelMux,
  output logic [2:0] referenceSwitch,
  output logic [9:0] resultCode
);

  adcsel_pkg::adcsel_state_type s_q;
  adcsel_pkg::adcsel_state_type s_d;
  logic [9:0] decodedMux;
  logic [2:0] decodedRef;
  logic [4:0] convLast;
  logic busy;
  logic lastCycle;
  logic complete;
  logic sleepStart;

  // mux and switch follow the applied copy, never the buffer
  adcsel_decode i_adcsel_decode (
    .channel(s_q.appliedChannel), // [R16]
    .reference(s_q.appliedReference),
    .channelMux(decodedMux),
    .referenceSwitch(decodedRef)
  );

  assign convLast = s_q.firstDone ? (`ADCSEL_NORMAL_LEN - 5'd1)
                                  : (`ADCSEL_FIRST_LEN - 5'd1);
  assign busy = (s_q.phase == adcsel_pkg::PhaseConvert);
  assign lastCycle = busy && (s_q.cycle == convLast);
  assign complete = lastCycle && adcClkTick && converterEnable;
  // converter enable is never touched by sleep logic
  assign sleepStart = cpuHalted && !s_q.haltedPrev && converterEnable &&
    !busy && !s_q.startPending &&
    (sleepMode == adcsel_pkg::SleepIdle ||
     sleepMode == adcsel_pkg::SleepNoiseReduce); // [R11] [R13]

  always_comb begin
    s_d = s_q;
    s_d.haltedPrev = cpuHalted;

    // input synchroniser; a level counts once stages two and three agree
    s_d.overSync = {s_q.overSync[1:0], overRangePin};
    if (s_q.overSync[2] == s_q.overSync[1]) begin
      s_d.overRange = s_q.overSync[2];
    end

    if (selWrite) begin
      s_d.bufChannel = selWriteChannel;
      s_d.bufReference = selWriteReference;
    end

    // copy while enabled and idle or in the final cycle, else hold
    if (converterEnable && (!busy || lastCycle)) begin // [R02]
      s_d.appliedChannel = s_q.bufChannel; // [R01] [R03]
      s_d.appliedReference = s_q.bufReference; // [R01] [R03]
    end

    if (!converterEnable) begin
      s_d.phase = adcsel_pkg::PhaseIdle;
      s_d.cycle = 5'd0;
      s_d.startPending = 1'b0;
      s_d.firstDone = 1'b0;
    end else if (adcClkTick) begin
      if (!busy && s_q.startPending) begin
        s_d.phase = adcsel_pkg::PhaseConvert; // [R04]
        s_d.cycle = 5'd0;
        s_d.startPending = 1'b0;
      end else if (lastCycle) begin
        s_d.firstDone = 1'b1;
        s_d.result = s_q.overRange ? `ADCSEL_FULL_SCALE : sarCode; // [R08]
        if (autoTriggerEnable && freeRunning) begin
          s_d.cycle = 5'd0; // [R07]
        end else begin
          s_d.phase = adcsel_pkg::PhaseIdle;
          s_d.cycle = 5'd0;
        end
      end else if (busy) begin
        s_d.cycle = s_q.cycle + 5'd1;
      end
    end

    // starts wait for the next adc clock tick
    if (converterEnable && !busy && !s_q.startPending) begin
      if (conversionStartWrite || sleepStart ||
          (autoTriggerEnable && triggerEvent)) begin
        s_d.startPending = 1'b1; // [R04] [R11]
      end
    end

    if (doneFlagClear) begin
      s_d.doneFlag = 1'b0;
    end
    if (complete) begin
      s_d.doneFlag = 1'b1; // [R12]
    end
    s_d.completeIrq = s_d.doneFlag && completeIrqEnable; // [R12]

    s_d.channelMux = decodedMux; // [R16]
    s_d.referenceSwitch = decodedRef; // [R16]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{
        phase: adcsel_pkg::PhaseIdle,
        cycle: 5'd0,
        firstDone: 1'b0,
        startPending: 1'b0,
        bufChannel: `ADCSEL_RESET_CHANNEL,
        bufReference: `ADCSEL_RESET_REFERENCE,
        appliedChannel: `ADCSEL_RESET_CHANNEL,
        appliedReference: `ADCSEL_RESET_REFERENCE,
        channelMux: 10'h001,
        referenceSwitch: 3'h1,
        doneFlag: 1'b0,
        completeIrq: 1'b0,
        result: 10'h000,
        overSync: 3'h0,
        overRange: 1'b0,
        haltedPrev: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign conversionBusy = busy;
  assign conversionDoneFlag = s_q.doneFlag;
  assign completeIrq = s_q.completeIrq;
  assign bufferChannel = s_q.bufChannel;
  assign bufferReference = s_q.bufReference;
  assign appliedChannel = s_q.appliedChannel;
  assign appliedReference = s_q.appliedReference;
  assign channelMux = s_q.channelMux;
  assign referenceSwitch = s_q.referenceSwitch;
  assign resultCode = s_q.result;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  idle_copy_a: assert property ( // [R01]
    (converterEnable && !busy) |=>
      (appliedChannel == $past(s_q.bufChannel) &&
       appliedReference == $past(s_q.bufReference)))
    else $error("idle selection not copied");

  frozen_sel_a: assert property ( // [R02]
    (busy && !lastCycle) |=>
      ($stable(appliedChannel) && $stable(appliedReference)))
    else $error("applied selection moved during conversion");

  last_copy_a: assert property ( // [R03]
    (lastCycle && converterEnable) |=>
      (appliedChannel == $past(s_q.bufChannel)))
    else $error("final cycle did not copy selection");

  start_wait_a: assert property ( // [R04]
    (conversionStartWrite && converterEnable && !busy &&
     !s_q.startPending) |=> (s_q.startPending && !busy))
    else $error("start not held for next tick");

  tick_start_a: assert property ( // [R04]
    (s_q.startPending && adcClkTick && converterEnable && !busy) |=>
      (busy && s_q.cycle == 5'd0))
    else $error("pending start not taken on tick");

  free_run_a: assert property ( // [R07]
    (complete && autoTriggerEnable && freeRunning) |=>
      (busy && s_q.cycle == 5'd0) ##1 $stable(appliedChannel))
    else $error("free running restart wrong");

  full_scale_a: assert property ( // [R08]
    (complete && s_q.overRange) |=> (resultCode == 10'h3ff))
    else $error("over range not full scale");

  sleep_start_a: assert property ( // [R11]
    sleepStart |=> s_q.startPending)
    else $error("sleep entry did not request start");

  done_irq_a: assert property ( // [R12]
    (complete && completeIrqEnable) |=> (conversionDoneFlag && completeIrq))
    else $error("completion interrupt missing");

  ground_mux_a: assert property ( // [R15]
    (appliedChannel == 4'hf) |=> (channelMux == 10'h200))
    else $error("ground channel not selected");

  ref_onehot_a: assert property ( // [R14]
    $onehot0(referenceSwitch))
    else $error("reference switch not one hot");

  ref_reserved_a: assert property ( // [R14]
    (appliedReference == 2'h2) |=> (referenceSwitch == 3'h0))
    else $error("reserved reference code drives a switch");

endmodule

`default_nettype wire

// ### tb/adcsel_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module adcsel_cpu_model #(
  parameter int TickPeriod = 4
) (
  input wire logic mclk,
  output logic selWrite,
  output logic [3:0] selWriteChannel,
  output logic [1:0] selWriteReference,
  output logic conversionStartWrite,
  output logic doneFlagClear
);
  initial begin
    selWrite = 1'b0;
    selWriteChannel = 4'h0;
    selWriteReference = 2'h0;
    conversionStartWrite = 1'b0;
    doneFlagClear = 1'b0;
  end

  // channel and reference always written together; released data inverts
  task automatic writeSel(input logic [3:0] ch, input logic [1:0] rf);
    @(negedge mclk);
    selWrite = 1'b1;
    selWriteChannel = ch;
    selWriteReference = rf;
    @(negedge mclk);
    selWrite = 1'b0;
    selWriteChannel = ~ch;
    selWriteReference = ~rf;
  endtask

  // no reselect until an adc clock has passed after the start
  task automatic startConv();
    @(negedge mclk);
    conversionStartWrite = 1'b1;
    @(negedge mclk);
    conversionStartWrite = 1'b0;
    repeat (2 * TickPeriod) @(negedge mclk);
  endtask

  task automatic clearDone();
    @(negedge mclk);
    doneFlagClear = 1'b1;
    @(negedge mclk);
    doneFlagClear = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### tb/test_adcsel_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin badCount++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module test_adcsel_top;
  logic mclk, reset_n, selWrite, conversionStartWrite, triggerEvent;
  logic adcClkTick = 1'b0;
  logic converterEnable, autoTriggerEnable, freeRunning, doneFlagClear;
  logic completeIrqEnable, cpuHalted, overRangePin;
  logic [3:0] selWriteChannel, bufferChannel, appliedChannel;
  logic [1:0] selWriteReference, bufferReference, appliedReference;
  logic [9:0] sarCode, channelMux, resultCode;
  logic [2:0] referenceSwitch;
  logic conversionBusy, conversionDoneFlag, completeIrq;
  logic [1:0] tickCnt = 2'h0;
  adcsel_pkg::adcsel_sleep_type sleepMode;
  int badCount = 0;
  int checked = 0;

  adcsel_cpu_model i_adcsel_cpu_model (.mclk(mclk), .selWrite(selWrite),
    .selWriteChannel(selWriteChannel), .selWriteReference(selWriteReference),
    .conversionStartWrite(conversionStartWrite),
    .doneFlagClear(doneFlagClear));

  adcsel_top i_adcsel_top (.mclk(mclk), .reset_n(reset_n),
    .adcClkTick(adcClkTick), .selWrite(selWrite),
    .selWriteChannel(selWriteChannel), .selWriteReference(selWriteReference),
    .converterEnable(converterEnable), .autoTriggerEnable(autoTriggerEnable),
    .freeRunning(freeRunning), .conversionStartWrite(conversionStartWrite),
    .triggerEvent(triggerEvent), .doneFlagClear(doneFlagClear),
    .completeIrqEnable(completeIrqEnable), .sleepMode(sleepMode),
    .cpuHalted(cpuHalted), .sarCode(sarCode), .overRangePin(overRangePin),
    .conversionBusy(conversionBusy), .conversionDoneFlag(conversionDoneFlag),
    .completeIrq(completeIrq), .bufferChannel(bufferChannel),
    .bufferReference(bufferReference), .appliedChannel(appliedChannel),
    .appliedReference(appliedReference), .channelMux(channelMux),
    .referenceSwitch(referenceSwitch), .resultCode(resultCode));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // adc clock tick every fourth mclk cycle
  always @(negedge mclk) begin
    tickCnt <= tickCnt + 2'h1;
    adcClkTick <= (tickCnt == 2'h3);
  end

  function automatic logic [9:0] muxOf(input logic [3:0] c);
    if (c <= 4'h7) return 10'h001 << c;
    if (c == 4'he) return 10'h100;
    if (c == 4'hf) return 10'h200;
    return 10'h000;
  endfunction

  function automatic logic [2:0] refOf(input logic [1:0] r);
    return (r == 2'h2) ? 3'h0 : ((r == 2'h3) ? 3'h4 : (3'h1 << r));
  endfunction

  task automatic waitSig(input bit useDone, input logic v);
    int n;
    n = 0;
    while (((useDone ? conversionDoneFlag : conversionBusy) !== v)
           && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n < 300, 1'b1)
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    endOfTest();
  end

  initial begin
    reset_n = 1'b0;
    triggerEvent = 1'b0;
    converterEnable = 1'b0;
    autoTriggerEnable = 1'b0;
    freeRunning = 1'b0;
    completeIrqEnable = 1'b0;
    sleepMode = adcsel_pkg::SleepIdle;
    cpuHalted = 1'b0;
    sarCode = 10'h2a5;
    overRangePin = 1'b0;
    repeat (8) @(negedge mclk);
    `CHK(channelMux, 10'h001)
    `CHK(referenceSwitch, 3'h1)
    reset_n = 1'b1;
    converterEnable = 1'b1;
    // every channel and reference code, reserved ones too
    for (int c = 0; c < 16; c++) begin
      i_adcsel_cpu_model.writeSel(c[3:0], c[1:0]);
      repeat (3) @(negedge mclk);
      `CHK(bufferChannel, c[3:0])
      `CHK(bufferReference, c[1:0])
      `CHK(appliedChannel, c[3:0])
      `CHK(appliedReference, c[1:0])
      `CHK(channelMux, muxOf(c[3:0]))
      `CHK(referenceSwitch, refOf(c[1:0]))
    end
    // first result after a reference change is thrown away
    i_adcsel_cpu_model.writeSel(4'h3, 2'h1);
    i_adcsel_cpu_model.startConv();
    waitSig(1'b0, 1'b1);
    waitSig(1'b0, 1'b0);
    // selection frozen, copy resumes before the end
    i_adcsel_cpu_model.startConv();
    waitSig(1'b0, 1'b1);
    i_adcsel_cpu_model.writeSel(4'h5, 2'h3);
    repeat (4) @(negedge mclk);
    `CHK(appliedChannel, 4'h3)
    `CHK(appliedReference, 2'h1)
    `CHK(channelMux, 10'h008)
    `CHK(referenceSwitch, 3'h2)
    waitSig(1'b0, 1'b0);
    `CHK(appliedChannel, 4'h5)
    `CHK(resultCode, 10'h2a5)
    // input above the reference
    overRangePin = 1'b1;
    i_adcsel_cpu_model.startConv();
    waitSig(1'b0, 1'b1);
    waitSig(1'b0, 1'b0);
    `CHK(resultCode, 10'h3ff)
    overRangePin = 1'b0;
    // free running: change after completion lands on the result after next
    autoTriggerEnable = 1'b1;
    freeRunning = 1'b1;
    i_adcsel_cpu_model.clearDone();
    i_adcsel_cpu_model.startConv();
    waitSig(1'b1, 1'b1);
    i_adcsel_cpu_model.writeSel(4'h6, 2'h0);
    repeat (4) @(negedge mclk);
    `CHK(appliedChannel, 4'h5)
    i_adcsel_cpu_model.clearDone();
    waitSig(1'b1, 1'b1);
    `CHK(appliedChannel, 4'h6)
    autoTriggerEnable = 1'b0;
    waitSig(1'b0, 1'b0);
    // auto trigger: trigger during conversion ignored, write lands next
    freeRunning = 1'b0;
    autoTriggerEnable = 1'b1;
    triggerEvent = 1'b1;
    @(negedge mclk);
    triggerEvent = 1'b0;
    waitSig(1'b0, 1'b1);
    repeat (8) @(negedge mclk);
    i_adcsel_cpu_model.writeSel(4'h2, 2'h1);
    triggerEvent = 1'b1;
    @(negedge mclk);
    triggerEvent = 1'b0;
    `CHK(appliedChannel, 4'h6)
    waitSig(1'b0, 1'b0);
    `CHK(appliedChannel, 4'h2)
    repeat (8) @(negedge mclk);
    `CHK(conversionBusy, 1'b0)
    autoTriggerEnable = 1'b0;
    // sleep: power down starts nothing, noise reduce starts on halt
    i_adcsel_cpu_model.clearDone();
    completeIrqEnable = 1'b1;
    sleepMode = adcsel_pkg::SleepPowerDown;
    cpuHalted = 1'b1;
    repeat (40) @(negedge mclk);
    `CHK(conversionBusy, 1'b0)
    cpuHalted = 1'b0;
    sleepMode = adcsel_pkg::SleepNoiseReduce;
    @(negedge mclk);
    cpuHalted = 1'b1;
    waitSig(1'b0, 1'b1);
    cpuHalted = 1'b0;
    waitSig(1'b1, 1'b1);
    @(negedge mclk);
    `CHK(completeIrq, 1'b1)
    endOfTest();
  end
endmodule

`default_nettype wire
